/* aocp_correction_path.sv */
`default_nettype none

module aocp_correction_path (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_clock_in,
    input wire aocp_pkg::aocp_clk_cfg_t clock_setup,
    input wire aocp_pkg::aocp_chan_cfg_t [aocp_pkg::CH-1:0] channel_setup,
    input wire logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] raw_sample,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    output logic spi_dout,
    output logic spi_dout_oe,
    output logic sample_ready_n,
    output logic high_resolution_active,
    output logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] corrected_sample
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] mclk_sync; // master clock pin, two stages
    logic [1:0] cs_sync;   // chip select pin, two stages
    logic [1:0] sclk_sync; // serial clock pin, two stages
    logic mclk_last;       // previous synchronised master level
    logic cs_last;         // previous synchronised select level
    logic sclk_last;       // previous synchronised serial clock

    // stage one feeds stage two only
    always_ff @(posedge clock) begin
        if (rst) begin
            mclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            sclk_sync <= 2'h0;
            mclk_last <= 1'b0;
            cs_last <= 1'b1;
            sclk_last <= 1'b0;
        end else begin
            mclk_sync <= {mclk_sync[0], master_clock_in};
            cs_sync <= {cs_sync[0], spi_cs_n};
            sclk_sync <= {sclk_sync[0], spi_sclk};
            mclk_last <= mclk_sync[1];
            cs_last <= cs_sync[1];
            sclk_last <= sclk_sync[1];
        end
    end

    wire mclk_rise = mclk_sync[1] & ~mclk_last;   // master clock rising edge
    wire cs_fall = ~cs_sync[1] & cs_last;         // host begins a read
    wire sclk_rise = sclk_sync[1] & ~sclk_last;   // leading edge, mode 0/1
    wire cs_active = ~cs_sync[1];                 // select held low

    // ------------------------------------------------------------
    // modulator clock and sample period
    // ------------------------------------------------------------
    logic mod_phase;                 // divide-by-two state
    logic [aocp_pkg::CNT_W-1:0] mod_cnt; // ticks within the sample period

    // every second master edge is one modulator tick
    wire mod_tick = mclk_rise & mod_phase; // R1
    wire [aocp_pkg::CNT_W-1:0] ratio =
        aocp_pkg::OSR_BASE << clock_setup.oversampling_ratio; // R10
    wire [aocp_pkg::CNT_W-1:0] ratio_m1 = ratio - 15'h0001;
    wire frame_end = mod_tick & (mod_cnt == ratio_m1); // R2

    // counter wraps at the configured ratio
    always_ff @(posedge clock) begin
        if (rst) begin
            mod_phase <= 1'b0;
            mod_cnt <= '0;
        end else begin
            if (mclk_rise) begin
                mod_phase <= ~mod_phase; // R1
            end
            if (frame_end) begin
                mod_cnt <= '0; // R2
            end else if (mod_tick) begin
                // a shrinking ratio can leave the count above the end
                mod_cnt <= (mod_cnt > ratio_m1) ? '0 : mod_cnt + 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // per-channel capture and correction
    // ------------------------------------------------------------
    logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] held;   // phase-aligned raw values
    logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] result; // corrected, saturated
    logic [aocp_pkg::CH-1:0] cap_now;                  // capture strobes

    genvar gi;
    generate
        for (gi = 0; gi < aocp_pkg::CH; gi++) begin : g_chan
            wire [aocp_pkg::CNT_W-1:0] phase =
                {5'h00, channel_setup[gi].phase_delay_field};
            // a delay beyond the period falls back to the period start
            wire [aocp_pkg::CNT_W-1:0] cap_at = (phase < ratio) ? phase : '0;
            wire [aocp_pkg::SW-1:0] source =
                channel_setup[gi].input_on_pins ? raw_sample[gi] : '0; // R11
            wire [aocp_pkg::SW-1:0] offset =
                {channel_setup[gi].offset_corr_high, channel_setup[gi].offset_corr_low};
            wire [aocp_pkg::SW-1:0] gain =
                {channel_setup[gi].gain_corr_high, channel_setup[gi].gain_corr_low};
            // offset first, then gain, only this channel's settings
            wire signed [aocp_pkg::SW:0] diff =
                $signed({held[gi][23], held[gi]}) - $signed({offset[23], offset}); // R3 R13
            wire signed [49:0] prod = diff * $signed({1'b0, gain}); // R4 R13
            wire signed [26:0] scaled = prod[49:aocp_pkg::GAIN_FRAC];
            // clip rather than wrap so large gains stay monotonic
            assign result[gi] = ~clock_setup.channel_enable[gi] ? '0 :
                (scaled > aocp_pkg::SAT_MAX) ? aocp_pkg::SAT_MAX[23:0] :
                (scaled < aocp_pkg::SAT_MIN) ? aocp_pkg::SAT_MIN[23:0] :
                scaled[23:0]; // R10
            assign cap_now[gi] = mod_tick & (mod_cnt == cap_at); // R5

            // capture at this channel's own delayed instant
            always_ff @(posedge clock) begin
                if (rst) begin
                    held[gi] <= '0;
                end else if (cap_now[gi]) begin
                    held[gi] <= source; // R5
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // result registers and ready strobe
    // ------------------------------------------------------------
    logic relower; // ready must fall again after a forced rise

    // new set loads at period end; an unread set is replaced
    always_ff @(posedge clock) begin
        if (rst) begin
            corrected_sample <= '0;
            sample_ready_n <= 1'b1;
            relower <= 1'b0;
            high_resolution_active <= 1'b0;
        end else begin
            high_resolution_active <= clock_setup.high_resolution_mode;
            relower <= 1'b0;
            if (frame_end) begin
                corrected_sample <= result; // R3 R4
            end
            if (frame_end & ~sample_ready_n) begin
                // still low from an unread set: rise now so a fresh fall shows
                sample_ready_n <= 1'b1;
                relower <= 1'b1;
            end else if (frame_end | relower) begin
                sample_ready_n <= 1'b0; // R6
            end else if (cs_fall) begin
                sample_ready_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // serial readout
    // ------------------------------------------------------------
    logic [aocp_pkg::FRAME_BITS-1:0] shift; // words, channel 0 first, msb first
    logic [aocp_pkg::BIT_W-1:0] bit_cnt;    // bits already presented

    // data changes on the leading edge so the host samples on the trailing one
    always_ff @(posedge clock) begin
        if (rst) begin
            shift <= '0;
            bit_cnt <= '0;
            spi_dout <= 1'b0;
            spi_dout_oe <= 1'b0;
        end else begin
            spi_dout_oe <= cs_active; // R12
            if (cs_fall) begin
                shift <= {corrected_sample[0], corrected_sample[1],
                          corrected_sample[2], corrected_sample[3]};
                bit_cnt <= '0;
                spi_dout <= 1'b0;
            end else if (cs_active & sclk_rise) begin
                spi_dout <= shift[aocp_pkg::FRAME_BITS-1];
                shift <= {shift[aocp_pkg::FRAME_BITS-2:0], 1'b0};
                // extra clocks past the last bit shift out zeros
                if (bit_cnt != aocp_pkg::LAST_BIT) begin
                    bit_cnt <= bit_cnt + 7'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_mod_half;
        @(posedge clock) disable iff (rst)
        mod_tick |-> mclk_rise && mod_phase ##1 !mod_phase;
    endproperty
    a_mod_half: assert property (p_mod_half) else $error("tick not on every second edge"); // R1

    property p_frame_end;
        @(posedge clock) disable iff (rst)
        frame_end |=> mod_cnt == '0;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("count did not wrap"); // R2

    property p_offset_only;
        @(posedge clock) disable iff (rst)
        frame_end && clock_setup.channel_enable[0]
            && channel_setup[0].gain_corr_high == 16'h8000
            && channel_setup[0].gain_corr_low == 8'h00
            && held[0] == {channel_setup[0].offset_corr_high,
                           channel_setup[0].offset_corr_low}
        |=> corrected_sample[0] == '0;
    endproperty
    a_offset_only: assert property (p_offset_only) else $error("offset not removed"); // R3

    property p_gain_zero;
        @(posedge clock) disable iff (rst)
        frame_end && channel_setup[1].gain_corr_high == 16'h0000
            && channel_setup[1].gain_corr_low == 8'h00
        |=> corrected_sample[1] == '0;
    endproperty
    a_gain_zero: assert property (p_gain_zero) else $error("gain not applied"); // R4

    property p_phase_cap;
        @(posedge clock) disable iff (rst)
        mod_tick && channel_setup[2].input_on_pins
            && mod_cnt == {5'h00, channel_setup[2].phase_delay_field}
        |=> held[2] == $past(raw_sample[2]);
    endproperty
    a_phase_cap: assert property (p_phase_cap) else $error("delayed capture missed"); // R5

    property p_ready_fall;
        @(posedge clock) disable iff (rst)
        frame_end |-> ##[1:2] !sample_ready_n;
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall"); // R6

    property p_disabled;
        @(posedge clock) disable iff (rst)
        frame_end && !clock_setup.channel_enable[3] |=> corrected_sample[3] == '0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel not zero"); // R10

    property p_shorted;
        @(posedge clock) disable iff (rst)
        cap_now[1] && !channel_setup[1].input_on_pins |=> held[1] == '0;
    endproperty
    a_shorted: assert property (p_shorted) else $error("shorted input not zero"); // R11

    property p_release;
        @(posedge clock) disable iff (rst)
        cs_sync[1] |=> !spi_dout_oe;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected"); // R12

    property p_isolated;
        @(posedge clock) disable iff (rst)
        frame_end && clock_setup.channel_enable[0] && held[0] == '0
            && channel_setup[0].offset_corr_high == 16'h0000
            && channel_setup[0].offset_corr_low == 8'h00
        |=> corrected_sample[0] == '0;
    endproperty
    a_isolated: assert property (p_isolated) else $error("other channel leaked in"); // R13

endmodule

`default_nettype wire

/* aocp_correction_path_bench.sv */
`default_nettype none

module aocp_correction_path_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock;
    logic rst;
    logic master_clock_in;
    logic spi_cs_n;
    logic spi_sclk;
    logic spi_dout;
    logic spi_dout_oe;
    logic sample_ready_n;
    logic high_resolution_active;
    aocp_pkg::aocp_clk_cfg_t clock_setup;
    aocp_pkg::aocp_chan_cfg_t [aocp_pkg::CH-1:0] channel_setup;
    logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] raw_sample;
    logic [aocp_pkg::CH-1:0][aocp_pkg::SW-1:0] corrected_sample;
    logic [95:0] exp_frame; // expected serial frame
    logic [95:0] frame; // frame read back
    logic oe_ok; // enable held through the read
    int n; // clocks between ready falls
    int errors = 0;
    int tests_run = 0;

    aocp_correction_path dut (.clock(clock), .rst(rst), .master_clock_in(master_clock_in),
        .clock_setup(clock_setup), .channel_setup(channel_setup), .raw_sample(raw_sample),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_dout(spi_dout),
        .spi_dout_oe(spi_dout_oe), .sample_ready_n(sample_ready_n),
        .high_resolution_active(high_resolution_active), .corrected_sample(corrected_sample));
    aocp_host host (.clock(clock), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
        .master_clock_in(master_clock_in), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 64-bit reckoning keeps the product exact before saturation
    function automatic logic [23:0] expect_out(logic [23:0] raw, aocp_pkg::aocp_chan_cfg_t c,
        logic en);
        longint d;
        longint p;
        d = longint'($signed(c.input_on_pins ? raw : 24'h000000));
        d = d - longint'($signed({c.offset_corr_high, c.offset_corr_low}));
        p = (d * longint'({c.gain_corr_high, c.gain_corr_low})) >>> 23;
        if (!en) return 24'h000000;
        if (p > 64'sh7FFFFF) return 24'h7FFFFF;
        if (p < -64'sh800000) return 24'h800000;
        return p[23:0];
    endfunction

    task automatic check(string what, logic [95:0] seen, logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait for the next falling edge of ready
    task automatic wait_fall(output int cnt);
        cnt = 0;
        while (sample_ready_n !== 1'b1 && cnt < 20000) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        while (sample_ready_n !== 1'b0 && cnt < 20000) begin
            @(posedge clock);
            #1;
            cnt++;
        end
        if (cnt >= 20000) check("ready wait", 1, 0);
    endtask

    task automatic check_all();
        logic [23:0] e;
        for (int i = 0; i < 4; i++) begin
            e = expect_out(raw_sample[i], channel_setup[i], clock_setup.channel_enable[i]);
            exp_frame[95-24*i -: 24] = e;
            check("corrected", corrected_sample[i], e);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        clock_setup = '{3'h0, 4'hF, 1'b1};
        channel_setup[0] = '{1'b1, 10'h000, 16'h0000, 8'h00, 16'h8000, 8'h00};
        channel_setup[1] = '{1'b1, 10'h000, 16'hFFFF, 8'h00, 16'h8000, 8'h00};
        channel_setup[2] = '{1'b1, 10'h000, 16'h0000, 8'h00, 16'h4000, 8'h00};
        channel_setup[3] = '{1'b0, 10'h000, 16'h0000, 8'h10, 16'h7FFF, 8'hFF};
        raw_sample = {24'h555555, 24'h800000, 24'h7FFFFF, 24'h123456};
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        check("ready idle", sample_ready_n, 1);
        check("oe idle", spi_dout_oe, 0);
        check("reset result", corrected_sample, 0);
        wait_fall(n);
        wait_fall(n);
        check_all();
        check("hr", high_resolution_active, 1);
        host.read_frame(frame, oe_ok);
        check("frame", frame, exp_frame);
        check("oe in read", oe_ok, 1);
        check("ready after read", sample_ready_n, 1);
        repeat (6) @(posedge clock);
        #1;
        check("oe released", spi_dout_oe, 0);
        wait_fall(n);
        wait_fall(n);
        // the first re-fall lags by its one-cycle high pulse; measure re-fall to re-fall
        wait_fall(n);
        check("period 128", n, 2048);
        // unread sets keep re-falling; ch3 disabled, ch1 gain zero, ch0 input zero
        @(posedge clock);
        clock_setup <= '{3'h1, 4'h7, 1'b0};
        channel_setup[1].gain_corr_high <= 16'h0000;
        raw_sample[0] <= 24'h000000;
        wait_fall(n);
        wait_fall(n);
        wait_fall(n);
        check("period 256", n, 4096);
        check_all();
        check("hr off", high_resolution_active, 0);
        // ch0 captures 64 ticks late, ch1 at once
        @(posedge clock);
        clock_setup <= '{3'h0, 4'hF, 1'b1};
        channel_setup[0].phase_delay_field <= 10'h040;
        channel_setup[1].gain_corr_high <= 16'h8000;
        wait_fall(n);
        wait_fall(n);
        repeat (512) @(posedge clock);
        raw_sample[0] <= 24'h0ABCDE;
        raw_sample[1] <= 24'h0ABCDE;
        wait_fall(n);
        check("late ch0", corrected_sample[0], expect_out(24'h0ABCDE, channel_setup[0], 1));
        check("early ch1", corrected_sample[1], expect_out(24'h7FFFFF, channel_setup[1], 1));
        wait_fall(n);
        check_all();
        summarize();
    end
endmodule

`default_nettype wire

/* aocp_host.sv */
`default_nettype none

// host side: supplies master clock, reads frames as spi master
module aocp_host (
    input wire logic clock,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    output logic master_clock_in,
    output logic spi_cs_n,
    output logic spi_sclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_bit = 1'b0; // last value seen driven
    logic line; // level on the shared data wire
    // released wire shows the inverse, so stale data never passes
    assign line = spi_dout_oe ? spi_dout : ~last_bit;

    // ------------------------------------------------------------
    // master clock, eight system clocks a period
    // ------------------------------------------------------------
    initial begin
        master_clock_in = 1'b0;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        forever begin
            repeat (4) @(posedge clock);
            master_clock_in <= ~master_clock_in;
        end
    end

    // ------------------------------------------------------------
    // one full read of 96 bits, ten clocks a bit
    // ------------------------------------------------------------
    task automatic read_frame(output logic [95:0] f, output logic oe_ok);
        oe_ok = 1'b1;
        f = '0;
        @(posedge clock);
        spi_cs_n <= 1'b0;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 96; i++) begin
            spi_sclk <= 1'b1;
            repeat (5) @(posedge clock);
            spi_sclk <= 1'b0;
            f = {f[94:0], line};
            oe_ok = oe_ok & (spi_dout_oe === 1'b1);
            last_bit = line;
            repeat (5) @(posedge clock);
        end
        spi_cs_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* aocp_pkg.sv */
// What this block does
// R1: modulator clock is master clock halved
// R2: one sample set per oversampling ratio ticks
// R3: subtract per-channel offset from each result
// R4: scale each result by per-channel gain
// R5: per-channel phase delay shifts capture instant
// R6: falling ready strobe marks new sample set
// R7: host uses clock idle low, second-edge sampling
// R8: host reads all data within one period
// R9: host configures before servicing ready events
// R10: clock setup picks ratio, enables, mode
// R11: channel setup picks pin input, phase
// R12: serial output released while select high
// R13: offset before gain, channels independent
`default_nettype none

package aocp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CH = 4;              // channel count
    localparam int SW = 24;             // sample width
    localparam int FRAME_BITS = CH * SW; // bits shifted per read
    localparam int CNT_W = 15;          // modulator tick counter width
    localparam int BIT_W = 7;           // serial bit counter width

    // ------------------------------------------------------------
    // timing and arithmetic constants
    // ------------------------------------------------------------
    localparam int MOD_DIV = 2;                            // master to modulator
    localparam logic [CNT_W-1:0] OSR_BASE = 15'h0080;      // ratio code 0
    localparam logic [2:0] OSR_CODE_512 = 3'h2;            // example setting
    localparam int GAIN_FRAC = 23;                         // gain is 1.23 fixed
    localparam logic [SW-1:0] GAIN_UNITY = 24'h800000;     // gain of exactly one
    localparam logic signed [26:0] SAT_MAX = 27'sh07FFFFF; // largest result
    localparam logic signed [26:0] SAT_MIN = -27'sh0800000; // smallest result
    localparam logic [BIT_W-1:0] LAST_BIT = 7'h5F;         // final shift index

    // ------------------------------------------------------------
    // per-channel setup, offset and gain
    // ------------------------------------------------------------
    typedef struct packed {
        logic input_on_pins;              // 1: external pins, 0: shorted
        logic [9:0] phase_delay_field;    // capture delay in modulator ticks
        logic [15:0] offset_corr_high;    // offset upper bits
        logic [7:0] offset_corr_low;      // offset lower bits
        logic [15:0] gain_corr_high;      // gain upper bits
        logic [7:0] gain_corr_low;        // gain lower bits
    } aocp_chan_cfg_t;

    // ------------------------------------------------------------
    // clock setup shared by all channels
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] oversampling_ratio;   // ratio = 128 << code
        logic [CH-1:0] channel_enable;    // per-channel enables
        logic high_resolution_mode;       // power mode select
    } aocp_clk_cfg_t;

endpackage

`default_nettype wire
